// file: logic/ccr_pkg.sv
// Shared constants and types of the camera control register link
package ccr_pkg;

    // Local clock and serial clock timing
    localparam int CCR_CLK_NS = 100;
    localparam int CCR_SCL_LOW_NS = 500;
    localparam int CCR_SCL_HIGH_NS = 260;
    localparam int CCR_BUS_FREE_NS = 500;
    // Fast-mode plus caps the serial clock at 1000 kHz
    localparam int CCR_SCL_PERIOD_NS = 1000;
    localparam int CCR_SCL_LOW_CYC = (CCR_SCL_LOW_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;
    localparam int CCR_SCL_HIGH_MIN_CYC = (CCR_SCL_HIGH_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;
    localparam int CCR_SCL_REST_CYC = (CCR_SCL_PERIOD_NS - CCR_SCL_LOW_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;
    // High phase stretched so that low plus high never beats the period limit
    localparam int CCR_SCL_HIGH_CYC = (CCR_SCL_REST_CYC > CCR_SCL_HIGH_MIN_CYC) ? CCR_SCL_REST_CYC :
        CCR_SCL_HIGH_MIN_CYC;
    localparam int CCR_BUS_FREE_CYC = (CCR_BUS_FREE_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;

    // Target address on the bus; value is arbitrary
    localparam logic [6:0] CCR_TARGET_ADDR = 7'h2A;

    // Direction bit after the target address
    localparam logic CCR_RW_WRITE = 1'b0;
    localparam logic CCR_RW_READ = 1'b1;

    // Bit position of the acknowledge slot within a byte frame
    localparam logic [3:0] CCR_ACK_SLOT = 4'h8;

    // Register address areas
    localparam logic [15:0] CCR_CFG_LAST = 16'h0FFF;
    localparam logic [15:0] CCR_LIMIT_FIRST = 16'h1000;
    localparam logic [15:0] CCR_LIMIT_LAST = 16'h1FFF;
    localparam logic [15:0] CCR_MAKER_FIRST = 16'h3000;

    // Stored configuration bytes and value of anything unreadable
    localparam int CCR_STORE_DEPTH = 64;
    localparam logic [7:0] CCR_UNREADABLE = 8'h00;
    localparam logic [7:0] CCR_REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        CCR_AREA_CONFIG,
        CCR_AREA_LIMIT,
        CCR_AREA_MAKER,
        CCR_AREA_NONE
    } ccr_area_t;

endpackage : ccr_pkg

// file: logic/ccr_link_if.sv
// Two-wire link between the host controller and the register target
interface ccr_link_if;
    logic scl;
    logic sda;
    logic hostSdaO;
    logic hostSdaOe;
    logic targetSdaO;
    logic targetSdaOe;

    // Open-drain wire with pull-up: any enabled low driver wins
    assign sda = (hostSdaOe ? hostSdaO : 1'b1) & (targetSdaOe ? targetSdaO : 1'b1);

    modport host (
        output scl,
        output hostSdaO,
        output hostSdaOe,
        input sda
    );

    modport target (
        input scl,
        input sda,
        output targetSdaO,
        output targetSdaOe
    );
endinterface : ccr_link_if

// file: logic/ccr_sync.sv
// Two flip-flop level synchroniser
module ccr_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : ccr_sync

// file: logic/ccr_target.sv
// Register target end of the two-wire link, clocked by the serial clock
module ccr_target
    import ccr_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = CCR_TARGET_ADDR,
    parameter int DEPTH = CCR_STORE_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    ccr_link_if.target link,
    output logic regWrite,
    output logic [15:0] regWriteAddr,
    output logic [7:0] regWriteData,
    output logic linkStart,
    output logic linkStop
);
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [2:0] {
        CCR_T_IDLE,
        CCR_T_DEVADDR,
        CCR_T_ADDRH,
        CCR_T_ADDRL,
        CCR_T_WDATA,
        CCR_T_RDATA
    } ccr_tstate_t;

    ccr_tstate_t state;
    logic startTgl;
    logic startAck;
    logic stopTgl;
    logic stopAck;
    logic startSeen;
    logic stopSeen;
    logic [3:0] bitCnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] indexHi;
    logic [15:0] index;
    logic [7:0] mem [DEPTH];
    logic oe;
    logic next_oe;
    logic wrTgl;
    logic [15:0] wrAddr;
    logic [7:0] wrData;
    logic wrTglSync;
    logic wrTglLast;
    logic startSync;
    logic startLast;
    logic stopSync;
    logic stopLast;

    function automatic ccr_area_t areaOf(input logic [15:0] a);
        if (a <= CCR_CFG_LAST) begin
            return CCR_AREA_CONFIG;
        end else if (a >= CCR_LIMIT_FIRST && a <= CCR_LIMIT_LAST) begin
            return CCR_AREA_LIMIT;
        end else if (a >= CCR_MAKER_FIRST) begin
            return CCR_AREA_MAKER;
        end
        return CCR_AREA_NONE;
    endfunction : areaOf

    // Only the implemented part of the configuration area holds storage
    function automatic logic storable(input logic [15:0] a);
        return areaOf(a) == CCR_AREA_CONFIG && a < 16'(DEPTH);
    endfunction : storable

    function automatic logic [7:0] readAt(input logic [15:0] a);
        if (storable(a)) begin
            return mem[a[AW-1:0]];
        end
        return CCR_UNREADABLE;
    endfunction : readAt

    // Start and stop are the only SDA edges while SCL is high
    always_ff @(negedge link.sda or negedge resetn) begin
        if (!resetn) begin
            startTgl <= 1'b0;
        end else if (link.scl) begin
            startTgl <= ~startTgl;
        end
    end

    always_ff @(posedge link.sda or negedge resetn) begin
        if (!resetn) begin
            stopTgl <= 1'b0;
        end else if (link.scl) begin
            stopTgl <= ~stopTgl;
        end
    end

    assign startSeen = startTgl != startAck;
    assign stopSeen = stopTgl != stopAck;

    // Byte engine: samples SDA on the rising serial clock edge
    always_ff @(posedge link.scl or negedge resetn) begin
        if (!resetn) begin
            state <= CCR_T_IDLE;
            startAck <= 1'b0;
            stopAck <= 1'b0;
            bitCnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            indexHi <= 8'h00;
            index <= 16'h0000;
            wrTgl <= 1'b0;
            wrAddr <= 16'h0000;
            wrData <= 8'h00;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= CCR_REG_RESET;
            end
        end else begin
            stopAck <= stopTgl;
            if (startSeen) begin
                // Index is kept across a repeated start
                startAck <= startTgl;
                state <= CCR_T_DEVADDR;
                rx <= {7'h00, link.sda};
                bitCnt <= 4'h1;
            end else if (state == CCR_T_IDLE) begin
                bitCnt <= 4'h0;
            end else if (bitCnt != CCR_ACK_SLOT) begin
                rx <= {rx[6:0], link.sda};
                bitCnt <= bitCnt + 4'h1;
            end else begin
                bitCnt <= 4'h0;
                unique case (state)
                    CCR_T_DEVADDR: begin
                        if (rx[7:1] != OWN_ADDR) begin
                            state <= CCR_T_IDLE;
                        end else if (rx[0] == CCR_RW_READ) begin
                            state <= CCR_T_RDATA;
                            tx <= readAt(index);
                        end else begin
                            state <= CCR_T_ADDRH;
                        end
                    end
                    CCR_T_ADDRH: begin
                        indexHi <= rx;
                        state <= CCR_T_ADDRL;
                    end
                    CCR_T_ADDRL: begin
                        index <= {indexHi, rx};
                        state <= CCR_T_WDATA;
                    end
                    CCR_T_WDATA: begin
                        if (storable(index)) begin
                            mem[index[AW-1:0]] <= rx;
                        end
                        wrTgl <= ~wrTgl;
                        wrAddr <= index;
                        wrData <= rx;
                        index <= index + 16'h0001;
                    end
                    CCR_T_RDATA: begin
                        index <= index + 16'h0001;
                        if (!link.sda) begin
                            tx <= readAt(index + 16'h0001);
                        end else begin
                            state <= CCR_T_IDLE;
                        end
                    end
                    default: begin
                        state <= CCR_T_IDLE;
                    end
                endcase
            end
        end
    end

    // What the target drives during the coming high phase
    always_comb begin
        next_oe = 1'b0;
        unique case (state)
            CCR_T_DEVADDR: next_oe = bitCnt == CCR_ACK_SLOT && rx[7:1] == OWN_ADDR;
            CCR_T_ADDRH, CCR_T_ADDRL, CCR_T_WDATA: next_oe = bitCnt == CCR_ACK_SLOT;
            CCR_T_RDATA: next_oe = bitCnt != CCR_ACK_SLOT && !tx[3'h7 - bitCnt[2:0]];
            default: next_oe = 1'b0;
        endcase
    end

    // The registered drive enable oe only changes on the falling serial clock edge
    always_ff @(negedge link.scl or negedge resetn) begin
        if (!resetn) begin
            oe <= 1'b0;
        end else begin
            oe <= next_oe;
        end
    end

    // A stop or a fresh start releases the line at once
    assign link.targetSdaOe = oe && !stopSeen && !startSeen;
    assign link.targetSdaO = 1'b0;

    ccr_sync u_wrSync (
        .clk(clk),
        .resetn(resetn),
        .din(wrTgl),
        .dout(wrTglSync)
    );

    ccr_sync u_startSync (
        .clk(clk),
        .resetn(resetn),
        .din(startTgl),
        .dout(startSync)
    );

    ccr_sync u_stopSync (
        .clk(clk),
        .resetn(resetn),
        .din(stopTgl),
        .dout(stopSync)
    );

    // Address and data are long stable when the toggle arrives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrTglLast <= 1'b0;
            regWrite <= 1'b0;
            regWriteAddr <= 16'h0000;
            regWriteData <= 8'h00;
        end else begin
            wrTglLast <= wrTglSync;
            regWrite <= wrTglSync != wrTglLast;
            if (wrTglSync != wrTglLast) begin
                regWriteAddr <= wrAddr;
                regWriteData <= wrData;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startLast <= 1'b0;
            stopLast <= 1'b0;
            linkStart <= 1'b0;
            linkStop <= 1'b0;
        end else begin
            startLast <= startSync;
            stopLast <= stopSync;
            linkStart <= startSync != startLast;
            linkStop <= stopSync != stopLast;
        end
    end
endmodule : ccr_target

// file: logic/ccr_host.sv
// Host controller end of the two-wire link, making the serial clock
module ccr_host
    import ccr_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = CCR_TARGET_ADDR
) (
    input wire logic clk,
    input wire logic resetn,
    ccr_link_if.host link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdRead,
    input wire logic cmdSetIndex,
    input wire logic [15:0] cmdAddr,
    input wire logic [7:0] cmdLen,
    input wire logic [7:0] wrData,
    output logic wrTake,
    output logic rdValid,
    output logic [7:0] rdData,
    output logic done,
    output logic nack
);
    typedef enum logic [1:0] {CCR_H_IDLE, CCR_H_START, CCR_H_BIT, CCR_H_STOP} ccr_hstate_t;
    typedef enum logic [2:0] {CCR_P_DEVW, CCR_P_ADDRH, CCR_P_ADDRL, CCR_P_WDATA, CCR_P_DEVR, CCR_P_RDATA} ccr_phase_t;

    ccr_hstate_t state;
    ccr_phase_t phase;
    logic [1:0] step;
    logic [3:0] timer;
    logic [3:0] limit;
    logic [3:0] bitCnt;
    logic [7:0] txByte;
    logic [7:0] rxByte;
    logic [15:0] addr;
    logic isRead;
    logic [7:0] left;
    logic scl;
    logic sdaOe;
    logic bitOe;
    logic sdaSync;
    logic stepEnd;

    ccr_sync u_sdaSync (
        .clk(clk),
        .resetn(resetn),
        .din(link.sda),
        .dout(sdaSync)
    );

    always_comb begin
        if (state == CCR_H_STOP && step == 2'h2) begin
            limit = 4'(CCR_BUS_FREE_CYC);
        end else if (step == 2'h0 && state != CCR_H_IDLE) begin
            limit = 4'(CCR_SCL_LOW_CYC);
        end else begin
            limit = 4'(CCR_SCL_HIGH_CYC);
        end
    end

    assign stepEnd = timer == limit - 4'h1;

    // Host acknowledges each read byte except the last
    always_comb begin
        if (bitCnt != CCR_ACK_SLOT) begin
            bitOe = phase != CCR_P_RDATA && !txByte[3'h7 - bitCnt[2:0]];
        end else begin
            bitOe = phase == CCR_P_RDATA && left != 8'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= CCR_H_IDLE;
            phase <= CCR_P_DEVW;
            step <= 2'h0;
            timer <= 4'h0;
            bitCnt <= 4'h0;
            txByte <= 8'h00;
            rxByte <= 8'h00;
            addr <= 16'h0000;
            isRead <= 1'b0;
            left <= 8'h00;
            scl <= 1'b1;
            sdaOe <= 1'b0;
            wrTake <= 1'b0;
            rdValid <= 1'b0;
            rdData <= 8'h00;
            done <= 1'b0;
            nack <= 1'b0;
        end else begin
            wrTake <= 1'b0;
            rdValid <= 1'b0;
            done <= 1'b0;
            timer <= stepEnd ? 4'h0 : timer + 4'h1;
            unique case (state)
                CCR_H_IDLE: begin
                    timer <= 4'h0;
                    if (cmdValid) begin
                        isRead <= cmdRead;
                        addr <= cmdAddr;
                        left <= (cmdLen == 8'h00) ? 8'h01 : cmdLen;
                        nack <= 1'b0;
                        scl <= 1'b0;
                        step <= 2'h0;
                        state <= CCR_H_START;
                        if (cmdRead && !cmdSetIndex) begin
                            phase <= CCR_P_DEVR;
                            txByte <= {TARGET_ADDR, CCR_RW_READ};
                        end else begin
                            phase <= CCR_P_DEVW;
                            txByte <= {TARGET_ADDR, CCR_RW_WRITE};
                        end
                    end
                end
                CCR_H_START: begin
                    if (stepEnd) begin
                        step <= step + 2'h1;
                        unique case (step)
                            2'h0: scl <= 1'b1;
                            2'h1: sdaOe <= 1'b1;
                            default: begin
                                scl <= 1'b0;
                                step <= 2'h0;
                                bitCnt <= 4'h0;
                                state <= CCR_H_BIT;
                            end
                        endcase
                    end
                end
                CCR_H_BIT: begin
                    if (step == 2'h0) begin
                        if (timer == 4'h0) begin
                            sdaOe <= bitOe;
                        end
                        if (stepEnd) begin
                            scl <= 1'b1;
                            step <= 2'h1;
                        end
                    end else if (stepEnd) begin
                        scl <= 1'b0;
                        step <= 2'h0;
                        if (bitCnt != CCR_ACK_SLOT) begin
                            rxByte <= {rxByte[6:0], sdaSync};
                            bitCnt <= bitCnt + 4'h1;
                        end else begin
                            bitCnt <= 4'h0;
                            if (phase != CCR_P_RDATA && sdaSync) begin
                                nack <= 1'b1;
                                state <= CCR_H_STOP;
                            end else begin
                                unique case (phase)
                                    CCR_P_DEVW: begin
                                        phase <= CCR_P_ADDRH;
                                        txByte <= addr[15:8];
                                    end
                                    CCR_P_ADDRH: begin
                                        phase <= CCR_P_ADDRL;
                                        txByte <= addr[7:0];
                                    end
                                    CCR_P_ADDRL: begin
                                        if (isRead) begin
                                            phase <= CCR_P_DEVR;
                                            txByte <= {TARGET_ADDR, CCR_RW_READ};
                                            state <= CCR_H_START;
                                        end else begin
                                            phase <= CCR_P_WDATA;
                                            txByte <= wrData;
                                            wrTake <= 1'b1;
                                        end
                                    end
                                    CCR_P_WDATA: begin
                                        left <= left - 8'h01;
                                        if (left == 8'h01) begin
                                            state <= CCR_H_STOP;
                                        end else begin
                                            txByte <= wrData;
                                            wrTake <= 1'b1;
                                        end
                                    end
                                    CCR_P_DEVR: phase <= CCR_P_RDATA;
                                    CCR_P_RDATA: begin
                                        rdValid <= 1'b1;
                                        rdData <= rxByte;
                                        left <= left - 8'h01;
                                        if (left == 8'h01) begin
                                            state <= CCR_H_STOP;
                                        end
                                    end
                                    default: state <= CCR_H_STOP;
                                endcase
                            end
                        end
                    end
                end
                CCR_H_STOP: begin
                    if (step == 2'h0 && timer == 4'h0) begin
                        sdaOe <= 1'b1;
                    end
                    if (stepEnd) begin
                        step <= step + 2'h1;
                        unique case (step)
                            2'h0: scl <= 1'b1;
                            2'h1: sdaOe <= 1'b0;
                            default: begin
                                step <= 2'h0;
                                done <= 1'b1;
                                state <= CCR_H_IDLE;
                            end
                        endcase
                    end
                end
                default: state <= CCR_H_IDLE;
            endcase
        end
    end

    assign cmdReady = state == CCR_H_IDLE;
    assign link.scl = scl;
    assign link.hostSdaOe = sdaOe;
    assign link.hostSdaO = 1'b0;
endmodule : ccr_host

// file: test/ccr_link_properties.sv
// Wire-level assertions on the two-wire link between host and target
module ccr_link_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic hostSdaOe,
    input wire logic targetSdaOe
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_scl_high_len:
        assert property ($rose(scl) |-> scl[*3]) else $error("SCL high phase too short");
    chk_scl_low_len:
        assert property ($fell(scl) |-> !scl[*5]) else $error("SCL low phase too short");
    chk_no_contention:
        assert property (scl |-> !(hostSdaOe && targetSdaOe)) else $error("Both ends drive SDA");
    chk_start_by_host:
        assert property ($fell(sda) && scl && $past(scl) |-> hostSdaOe && !targetSdaOe)
            else $error("Start not made by host");
    chk_stop_bus_free:
        assert property ($rose(sda) && scl && $past(scl) |-> sda[*5]) else $error("Bus not free after stop");
    chk_target_on_fall:
        assert property ($rose(targetSdaOe) |-> $fell(scl)) else $error("Target drives off falling SCL");
    chk_target_low_change:
        assert property ($changed(targetSdaOe) |-> !scl) else $error("Target SDA changed while SCL high");
    chk_target_whole_bit:
        assert property ($rose(targetSdaOe) |-> targetSdaOe[*8]) else $error("Target bit not held whole");

    cover property ($fell(sda) && scl && $past(scl));
    cover property ($rose(targetSdaOe));
    cover property ($rose(sda) && scl && $past(scl));
endmodule : ccr_link_properties

// file: test/camera_control_register_target_test.sv
// Self-checking bench joining host and register target over the two-wire link
module camera_control_register_target_test import ccr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; $display("BAD %s expected %h seen %h", nm, e, g); end end
    logic clk = 1'b0;
    logic tclk = 1'b0;
    logic resetn;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic cmdSetIndex = 1'b0;
    logic [15:0] cmdAddr = 16'h0000;
    logic [7:0] cmdLen = 8'h00;
    logic [7:0] wrData, rdData, regWriteData;
    logic [15:0] regWriteAddr;
    logic cmdReady, wrTake, rdValid, done, nack, regWrite, linkStart, linkStop;
    logic [7:0] wbuf [8] = '{default: 8'h00};
    logic [15:0] areas [3] = '{16'h003F, 16'h1000, 16'h3000};
    logic [7:0] expv [3] = '{8'h5A, 8'h00, 8'h00};
    logic [7:0] rq [$];
    int wIdx = 0;
    int wCount = 0;
    int starts = 0;
    int stops = 0;
    int mismatches = 0;
    int samplesChecked = 0;

    assign wrData = wbuf[wIdx];

    ccr_link_if link ();
    ccr_host ccr_host_inst (.clk(clk), .resetn(resetn), .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdRead(cmdRead), .cmdSetIndex(cmdSetIndex), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrData(wrData),
        .wrTake(wrTake), .rdValid(rdValid), .rdData(rdData), .done(done), .nack(nack));
    ccr_target ccr_target_inst (.clk(tclk), .resetn(resetn), .link(link), .regWrite(regWrite),
        .regWriteAddr(regWriteAddr), .regWriteData(regWriteData), .linkStart(linkStart), .linkStop(linkStop));
    ccr_link_properties ccr_link_properties_inst (.clk(clk), .resetn(resetn), .scl(link.scl), .sda(link.sda),
        .hostSdaOe(link.hostSdaOe), .targetSdaOe(link.targetSdaOe));

    initial forever #50 clk = ~clk;
    initial begin
        #7;
        forever #15 tclk = ~tclk;
    end

    always @(posedge clk) begin
        if (wrTake) wIdx <= wIdx + 1;
        if (rdValid) rq.push_back(rdData);
    end
    always @(posedge tclk) begin
        if (regWrite) wCount <= wCount + 1;
        if (linkStart) starts <= starts + 1;
        if (linkStop) stops <= stops + 1;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // One host command, waited on until its done pulse
    task automatic run(input logic rd, input logic si, input logic [15:0] a, input int n);
        int k;
        rq.delete();
        @(posedge clk);
        cmdRead <= rd;
        cmdSetIndex <= si;
        cmdAddr <= a;
        cmdLen <= 8'(n);
        cmdValid <= 1'b1;
        wIdx <= 0;
        @(posedge clk);
        cmdValid <= 1'b0;
        @(posedge clk);
        `CHK("busy", 1'b0, cmdReady)
        for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clk);
        `CHK("done", 1'b1, done)
        `CHK("ready", 1'b1, cmdReady)
        `CHK("nack", 1'b0, nack)
    endtask : run

    initial begin
        // An edge on reset is needed so the asynchronous resets really fire
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        wbuf[0] <= 8'hA5;
        wbuf[1] <= 8'h3C;
        wbuf[2] <= 8'h0F;
        run(1'b0, 1'b1, 16'h0010, 3);
        `CHK("write count", 3, wCount)
        `CHK("write addr", 16'h0012, regWriteAddr)
        `CHK("write data", 8'h0F, regWriteData)
        run(1'b1, 1'b1, 16'h0010, 3);
        `CHK("starts", 3, starts)
        `CHK("stops", 2, stops)
        `CHK("read count", 3, rq.size())
        for (int i = 0; i < 3; i++) `CHK("seq read", wbuf[i], rq[i])
        run(1'b1, 1'b1, 16'h0010, 1);
        `CHK("single read", 8'hA5, rq[0])
        run(1'b1, 1'b0, 16'h0000, 2);
        `CHK("current read 0", 8'h3C, rq[0])
        `CHK("current read 1", 8'h0F, rq[1])
        wbuf[0] <= 8'h5A;
        for (int i = 0; i < 3; i++) begin
            run(1'b0, 1'b1, areas[i], 1);
            `CHK("area write addr", areas[i], regWriteAddr)
            run(1'b1, 1'b1, areas[i], 1);
            `CHK("area read", expv[i], rq[0])
        end
        finish_test();
    end

    initial begin
        #2_000_000;
        mismatches++;
        finish_test();
    end
endmodule : camera_control_register_target_test
